// ### rtl/dma_ctl_pkg.sv
// Package: register map, field positions and shared types of the DMA control unit
package dma_ctl_pkg;

   // ****************************************************************
   // Register map (printed offsets are halfword aligned: index * 2)
   // ****************************************************************
   localparam logic [31:0] idle_status_idx = 32'h0f00_0042;
   localparam logic [31:0] seq_enable_idx  = 32'h0f00_0044;
   localparam logic [31:0] chan_mask_idx   = 32'h0f00_0046;
   localparam logic [31:0] chan_req_idx    = 32'h0f00_0048;
   localparam logic [31:0] direction_idx   = 32'h0f00_004a;
   localparam logic [31:0] ctrl_idx        = 32'h0f00_0060;
   localparam logic [31:0] base_idx        = 32'h0f00_0000;
   localparam int          addr_w          = 4;

   // Word addresses relative to the block base
   localparam logic [3:0] a_idle   = 4'h1;
   localparam logic [3:0] a_sen    = 4'h2;
   localparam logic [3:0] a_mask   = 4'h3;
   localparam logic [3:0] a_req    = 4'h4;
   localparam logic [3:0] a_dir    = 4'h5;
   localparam logic [3:0] a_ctrl   = 4'h8;

   // ****************************************************************
   // Field positions and reset values
   // ****************************************************************
   localparam int ch_fir   = 0;
   localparam int ch_srx   = 1;
   localparam int ch_stx   = 2;
   localparam int ch_direction_a = 3;
   localparam int dir_fir_bit   = 0;
   localparam int dir_direction_a_bit = 1;
   localparam int ctrl_auto_bit = 0;
   localparam logic [15:0] idle_reset = 16'h0001;
   localparam logic [15:0] zero_reset = 16'h0000;
   localparam logic [31:0] unmapped_read = 32'h0000_0000;

   // ****************************************************************
   // Sequencer
   // ****************************************************************
   typedef enum logic [1:0] {
      seq_idle  = 2'b00,
      seq_xfer  = 2'b01,
      seq_done  = 2'b10
   } seq_state_type;

   typedef struct packed {
      logic       valid;
      logic [1:0] chan;
      logic       to_mem;
   } grant_type;

endpackage : dma_ctl_pkg

// ### rtl/dma_arbiter.sv
// Fixed priority arbiter over the four channel requests
`timescale 1ns/10ps
module dma_arbiter #(
   parameter int n_chan = 4
) (
   input  wire logic [n_chan-1:0] req,
   output logic                   valid,
   output logic [1:0]             chan
);
   initial begin
      if (n_chan != 4) $error("dma_arbiter needs four channels");
   end

   // Lowest index wins: FIR, serial rx, serial tx, I/O to RAM
   always_comb begin
      valid = 1'b0;
      chan  = 2'd0;
      for (int i = n_chan - 1; i >= 0; i--) begin
         if (req[i]) begin
            valid = 1'b1;
            chan  = 2'(i);
         end
      end
   end
endmodule : dma_arbiter

// ### rtl/dma_byte_counter.sv
// Byte counter of the I/O to RAM channel with terminal count
`timescale 1ns/10ps
module dma_byte_counter #(
   parameter int cnt_w = 16
) (
   input  wire logic             ref_clk,
   input  wire logic             rst_n,
   input  wire logic             load,
   input  wire logic [cnt_w-1:0] size,
   input  wire logic             step,
   output logic                  tc
);
   logic [cnt_w-1:0] cnt_q;
   logic [cnt_w-1:0] cnt_d;

   initial begin
      if (cnt_w < 2 || cnt_w > 32) $error("dma_byte_counter width");
   end

   always_comb begin
      cnt_d = cnt_q;
      if (load) begin
         cnt_d = size;
      end else if (step && cnt_q != '0) begin
         cnt_d = cnt_q - cnt_w'(1);
      end
   end

   assign tc = step && (cnt_q <= cnt_w'(1));

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end
endmodule : dma_byte_counter

// ### rtl/dma_channel_control_regs.sv
// DMA control unit: sequencer, channel enables, requests, direction
// ****************************************************************
// Summary of operation
// - Bit 0 of idle status reads 1 idle, 0 busy; resets to 1.
// - Sequencer enable bit 0 gates all four channels; resets to 0.
// - Mask bit 3 enables the I/O to RAM channel.
// - Mask bit 2 enables the serial transmit channel.
// - Mask bit 1 enables the serial receive channel.
// - Mask bit 0 enables FIR transmit; all enables reset to 0.
// - Request bit 3 is read/write: 1 active, 0 halted.
// - Request bits 2..0 read back pending serial tx, rx, FIR.
// - Only software starts I/O to RAM, by writing request bit 3.
// - Terminal count without auto reload clears request bit 3.
// - Writing 0 lets the current transfer finish, then stops.
// - Direction bit 1: 1 external I/O to memory, 0 reverse.
// - Direction bit 0: 1 internal I/O to memory, 0 reverse.
// - Reserved bits read zero; software writes them as zero.
// - Default priority: FIR, serial rx, serial tx, I/O to RAM.
// - With auto reload, terminal count reloads address and continues.
// ****************************************************************
//
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/10ps
module dma_channel_control_regs #(
   parameter int cnt_w = 16
) (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        serial_tx_req,
   input  wire logic        serial_rx_req,
   input  wire logic        fir_req,
   input  wire logic        xfer_ack,
   output logic             xfer_start,
   output logic [1:0]       xfer_chan,
   output logic             xfer_to_mem,
   output logic             addr_reload
);
   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic                          seq_enable_bit;
      logic [3:0]                    chan_enable;
      logic                          direction_a_request;
      logic [1:0]                    direction;
      logic                          auto_reload_enable;
      logic [cnt_w-1:0]              byte_size;
      logic [3:0]                    pending;
      dma_ctl_pkg::seq_state_type    seq;
      dma_ctl_pkg::grant_type        grant;
      logic                          seq_idle_flag;
      logic                          start;
      logic                          reload;
      logic                          ack;
      logic [31:0]                   rdata;
   } state_type;

   state_type s_q;
   state_type s_d;

   logic       arb_valid;
   logic [1:0] arb_chan;
   logic       tc;
   logic       cnt_load;
   logic       cnt_step;
   logic [3:0] serve_req;
   logic       wr_hit;
   logic       rd_hit;

   initial begin
      if (cnt_w < 2 || cnt_w > 16) $error("cnt_w out of range");
   end

   function automatic logic sel(input logic [3:0] a, input logic [3:0] r);
      sel = (a == r);
   endfunction : sel

   // ****************************************************************
   // Arbitration and byte count
   // ****************************************************************
   assign serve_req = s_q.seq_enable_bit ?
                      (s_q.pending & s_q.chan_enable) : 4'h0;

   dma_arbiter #(.n_chan(4)) u_arb (
      .req   (serve_req),
      .valid (arb_valid),
      .chan  (arb_chan)
   );

   // Software start or auto reload refills the count
   assign cnt_load = wr_hit && avs_byteenable[0] &&
                     sel(avs_address, dma_ctl_pkg::a_req) &&
                     avs_writedata[dma_ctl_pkg::ch_direction_a] &&
                     !s_q.direction_a_request || s_q.reload;
   assign cnt_step = s_q.seq == dma_ctl_pkg::seq_xfer && xfer_ack &&
                     s_q.grant.chan == 2'(dma_ctl_pkg::ch_direction_a);

   dma_byte_counter #(.cnt_w(cnt_w)) u_cnt (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .load    (cnt_load),
      .size    (s_q.byte_size),
      .step    (cnt_step),
      .tc      (tc)
   );

   // Bus answers one cycle after the request is seen
   assign wr_hit = avs_write && s_q.ack;
   assign rd_hit = avs_read && s_q.ack;

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      s_d        = s_q;
      s_d.start  = 1'b0;
      s_d.reload = 1'b0;
      s_d.ack    = (avs_read || avs_write) && !s_q.ack;
      s_d.pending = {s_q.direction_a_request, serial_tx_req, serial_rx_req,
                     fir_req};
      if (wr_hit && avs_byteenable[0]) begin
         case (avs_address)
            dma_ctl_pkg::a_sen:
               s_d.seq_enable_bit = avs_writedata[0];
            dma_ctl_pkg::a_mask:
               s_d.chan_enable = avs_writedata[3:0];
            dma_ctl_pkg::a_req:
               s_d.direction_a_request =
                  avs_writedata[dma_ctl_pkg::ch_direction_a];
            dma_ctl_pkg::a_dir:
               s_d.direction = avs_writedata[1:0];
            dma_ctl_pkg::a_ctrl: begin
               s_d.auto_reload_enable =
                  avs_writedata[dma_ctl_pkg::ctrl_auto_bit];
               s_d.byte_size = avs_writedata[cnt_w+15:16];
            end
            default: begin
            end
         endcase
      end
      case (s_q.seq)
         dma_ctl_pkg::seq_idle: begin
            if (arb_valid) begin
               s_d.grant.valid = 1'b1;
               s_d.grant.chan  = arb_chan;
               s_d.grant.to_mem = (arb_chan ==
                  2'(dma_ctl_pkg::ch_direction_a)) ?
                  s_q.direction[dma_ctl_pkg::dir_direction_a_bit] :
                  (arb_chan == 2'(dma_ctl_pkg::ch_fir)) ?
                  s_q.direction[dma_ctl_pkg::dir_fir_bit] :
                  (arb_chan == 2'(dma_ctl_pkg::ch_srx));
               s_d.start = 1'b1;
               s_d.seq   = dma_ctl_pkg::seq_xfer;
            end
         end
         dma_ctl_pkg::seq_xfer: begin
            // Transfer in flight always completes before stopping
            if (xfer_ack) begin
               s_d.seq = dma_ctl_pkg::seq_done;
               if (tc) begin
                  if (s_q.auto_reload_enable) begin
                     s_d.reload = 1'b1;
                  end else begin
                     s_d.direction_a_request = 1'b0;
                  end
               end
            end
         end
         dma_ctl_pkg::seq_done: begin
            s_d.grant.valid = 1'b0;
            s_d.seq = dma_ctl_pkg::seq_idle;
         end
         default: s_d.seq = dma_ctl_pkg::seq_idle;
      endcase
      s_d.seq_idle_flag = (s_d.seq == dma_ctl_pkg::seq_idle);
      s_d.rdata = dma_ctl_pkg::unmapped_read;
      if ((avs_read) && !s_q.ack) begin
         case (avs_address)
            dma_ctl_pkg::a_idle:
               s_d.rdata = {31'h0, s_q.seq_idle_flag};
            dma_ctl_pkg::a_sen:
               s_d.rdata = {31'h0, s_q.seq_enable_bit};
            dma_ctl_pkg::a_mask:
               s_d.rdata = {28'h0, s_q.chan_enable};
            dma_ctl_pkg::a_req:
               s_d.rdata = {28'h0, s_q.direction_a_request, serial_tx_req,
                            serial_rx_req, fir_req};
            dma_ctl_pkg::a_dir:
               s_d.rdata = {30'h0, s_q.direction};
            dma_ctl_pkg::a_ctrl:
               s_d.rdata = {16'(s_q.byte_size), 15'h0,
                            s_q.auto_reload_enable};
            default: s_d.rdata = dma_ctl_pkg::unmapped_read;
         endcase
      end
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         s_q               <= '0;
         s_q.seq_idle_flag <= 1'b1;
         s_q.seq           <= dma_ctl_pkg::seq_idle;
      end else begin
         s_q <= s_d;
      end
   end

   assign avs_readdata    = s_q.rdata;
   assign avs_waitrequest = !s_q.ack;
   assign xfer_start      = s_q.start;
   assign xfer_chan       = s_q.grant.chan;
   assign xfer_to_mem     = s_q.grant.to_mem;
   assign addr_reload     = s_q.reload;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   a_idle_after_reset: assert property (@(posedge ref_clk)
      $rose(rst_n) |-> s_q.seq_idle_flag)
      else $error("idle flag not set after reset");
   a_busy_when_xfer: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_q.seq == dma_ctl_pkg::seq_xfer |-> !s_q.seq_idle_flag)
      else $error("idle flag set during transfer");
   a_start_needs_en: assert property (@(posedge ref_clk) disable iff (!rst_n)
      xfer_start |-> $past(s_q.seq_enable_bit))
      else $error("start without sequencer enable");
   a_start_chan_en: assert property (@(posedge ref_clk) disable iff (!rst_n)
      xfer_start |-> $past(s_q.chan_enable[arb_chan]
      && s_q.pending[arb_chan]))
      else $error("start on masked channel");
   a_fir_first: assert property (@(posedge ref_clk) disable iff (!rst_n)
      arb_valid && serve_req[dma_ctl_pkg::ch_fir]
      |-> arb_chan == 2'(dma_ctl_pkg::ch_fir))
      else $error("FIR not preferred");
   a_tc_clears: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_q.seq == dma_ctl_pkg::seq_xfer && xfer_ack && tc
      && !s_q.auto_reload_enable && !wr_hit |=> !s_q.direction_a_request)
      else $error("request not cleared at terminal count");
   a_tc_reload: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_q.seq == dma_ctl_pkg::seq_xfer && xfer_ack && tc
      && s_q.auto_reload_enable |=> addr_reload)
      else $error("no reload at terminal count");
   a_finish_xfer: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_q.seq == dma_ctl_pkg::seq_xfer && !xfer_ack
      |=> s_q.seq == dma_ctl_pkg::seq_xfer)
      else $error("transfer dropped before ack");
   a_rsvd_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !avs_waitrequest && $past(avs_address) == dma_ctl_pkg::a_req
      |-> avs_readdata[31:4] == 28'h0)
      else $error("reserved bits not zero");
   a_sw_start: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $rose(s_q.direction_a_request) |-> $past(wr_hit))
      else $error("I/O to RAM start without write");
   a_ack_one: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus answer late");

   c_direction_a_run: cover property (@(posedge ref_clk) disable iff (!rst_n)
      xfer_start && xfer_chan == 2'(dma_ctl_pkg::ch_direction_a));
   c_reload: cover property (@(posedge ref_clk) disable iff (!rst_n)
      addr_reload);
   c_tc_stop: cover property (@(posedge ref_clk) disable iff (!rst_n)
      $fell(s_q.direction_a_request) && !$past(wr_hit));
endmodule : dma_channel_control_regs

// ### verif/dma_periph_model.sv
// Peripheral model: raises DMA requests and acknowledges transfers
`timescale 1ns/10ps
module dma_periph_model (
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   input  wire logic [2:0] pend_set,
   input  wire logic       slow,
   input  wire logic       xfer_start,
   input  wire logic [1:0] xfer_chan,
   output logic            fir_req,
   output logic            serial_rx_req,
   output logic            serial_tx_req,
   output logic            xfer_ack
);
   logic [2:0] pend_q;
   logic [2:0] clr;
   logic [1:0] chan_q;
   logic [3:0] wait_q;
   logic       busy_q;
   logic       last;

   assign fir_req       = pend_q[0];
   assign serial_rx_req = pend_q[1];
   assign serial_tx_req = pend_q[2];
   assign last          = busy_q && (wait_q == 4'h0);

   // Request drops only with the ack of its own transfer
   always_comb begin
      clr = 3'h0;
      if (last && chan_q != 2'h3) begin
         clr = 3'h1 << chan_q;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pend_q   <= 3'h0;
         chan_q   <= 2'h0;
         wait_q   <= 4'h0;
         busy_q   <= 1'b0;
         xfer_ack <= 1'b0;
      end else begin
         xfer_ack <= last;
         pend_q   <= (pend_q | pend_set) & ~clr;
         if (xfer_start) begin
            busy_q <= 1'b1;
            chan_q <= xfer_chan;
            wait_q <= slow ? 4'hc : 4'h2;
         end else if (last) begin
            busy_q <= 1'b0;
         end else if (busy_q) begin
            wait_q <= wait_q - 4'h1;
         end
      end
   end
endmodule : dma_periph_model

// ### verif/dma_channel_control_regs_bench.sv
// Self-checking bench of the DMA control unit
`timescale 1ns/10ps
module dma_channel_control_regs_bench;
   logic        ref_clk;
   logic        rst_n;
   logic [3:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [3:0]  avs_byteenable;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        serial_tx_req;
   logic        serial_rx_req;
   logic        fir_req;
   logic        xfer_ack;
   logic        xfer_start;
   logic [1:0]  xfer_chan;
   logic        xfer_to_mem;
   logic        addr_reload;
   logic [2:0]  pend_set;
   logic        slow;
   logic [2:0]  grants[$];
   logic [31:0] rd;
   int          errors;
   int          checks_done;
   int          reloads;
   int          acks;
   int          n;
   int          g;

   dma_channel_control_regs #(.cnt_w(16)) u_dut (
      .ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .serial_tx_req(serial_tx_req), .serial_rx_req(serial_rx_req),
      .fir_req(fir_req), .xfer_ack(xfer_ack), .xfer_start(xfer_start),
      .xfer_chan(xfer_chan), .xfer_to_mem(xfer_to_mem),
      .addr_reload(addr_reload));

   dma_periph_model u_periph (
      .ref_clk(ref_clk), .rst_n(rst_n), .pend_set(pend_set),
      .slow(slow), .xfer_start(xfer_start), .xfer_chan(xfer_chan),
      .fir_req(fir_req), .serial_rx_req(serial_rx_req),
      .serial_tx_req(serial_tx_req), .xfer_ack(xfer_ack));

   always #10 ref_clk = ~ref_clk;

   // Record grants as {channel, to_mem}
   always @(posedge ref_clk) begin
      if (xfer_start === 1'b1) grants.push_back({xfer_chan, xfer_to_mem});
      if (addr_reload === 1'b1) reloads++;
      if (xfer_ack === 1'b1) acks++;
   end

   // ****************************************************************
   // Bus tasks
   // ****************************************************************
   task automatic bus(input logic wr, input logic [3:0] a,
                      input logic [31:0] wd);
      int k;
      k = 0;
      avs_address   <= a;
      avs_writedata <= wd;
      avs_read      <= !wr;
      avs_write     <= wr;
      @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0 && k < 50) begin
         @(posedge ref_clk);
         k++;
      end
      if (k == 50) errors++;
      rd = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      @(posedge ref_clk);
   endtask : bus

   task cmp(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp

   task chk(input logic [3:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      cmp(rd, exp);
   endtask : chk

   task wr(input logic [3:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr

   task wait_grants(input int k);
      for (n = 0; n < 300 && grants.size() < k; n++) @(posedge ref_clk);
   endtask : wait_grants

   task wait_idle;
      rd = 32'h0000_0000;
      for (n = 0; n < 30 && rd[0] !== 1'b1; n++) begin
         bus(1'b0, dma_ctl_pkg::a_idle, 32'h0000_0000);
      end
   endtask : wait_idle

   task tally_and_finish;
      if (errors == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      repeat (20000) @(posedge ref_clk);
      errors++;
      tally_and_finish();
   end

   // ****************************************************************
   // Test sequence
   // ****************************************************************
   initial begin
      ref_clk = 1'b0;
      rst_n = 1'b0;
      avs_address = 4'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000_0000;
      avs_byteenable = 4'hf;
      pend_set = 3'h0;
      slow = 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      for (int i = 0; i < 6; i++) chk(4'(i), 32'(i == 1));
      wr(dma_ctl_pkg::a_dir, 32'h0000_0003);
      chk(dma_ctl_pkg::a_dir, 32'h0000_0003);
      wr(4'hf, 32'h0000_ffff);
      chk(4'hf, 32'h0000_0000);
      wr(dma_ctl_pkg::a_sen, 32'h0000_0000);
      chk(dma_ctl_pkg::a_sen, 32'h0000_0000);
      wr(dma_ctl_pkg::a_mask, 32'h0000_0004);
      pend_set <= 3'h7;
      @(posedge ref_clk);
      pend_set <= 3'h0;
      repeat (20) @(posedge ref_clk);
      cmp(32'(grants.size()), 32'h0000_0000);
      chk(dma_ctl_pkg::a_req, 32'h0000_0007);
      wr(dma_ctl_pkg::a_sen, 32'h0000_0001);
      wait_grants(1);
      repeat (20) @(posedge ref_clk);
      cmp(32'(grants.size()), 32'h0000_0001);
      chk(dma_ctl_pkg::a_req, 32'h0000_0003);
      wr(dma_ctl_pkg::a_mask, 32'h0000_000f);
      wait_grants(3);
      cmp({29'h0, grants[0]}, 32'h0000_0004);
      cmp({29'h0, grants[1]}, 32'h0000_0001);
      cmp({29'h0, grants[2]}, 32'h0000_0003);
      wr(dma_ctl_pkg::a_dir, 32'h0000_0001);
      wr(dma_ctl_pkg::a_ctrl, 32'h0003_0000);
      wr(dma_ctl_pkg::a_req, 32'h0000_0008);
      wait_grants(6);
      wait_idle();
      chk(dma_ctl_pkg::a_req, 32'h0000_0000);
      cmp(32'(grants.size()), 32'h0000_0006);
      cmp({29'h0, grants[5]}, 32'h0000_0006);
      slow <= 1'b1;
      wr(dma_ctl_pkg::a_dir, 32'h0000_0003);
      wr(dma_ctl_pkg::a_ctrl, 32'h0002_0001);
      wr(dma_ctl_pkg::a_req, 32'h0000_0008);
      for (n = 0; n < 300 && reloads == 0; n++) @(posedge ref_clk);
      cmp(32'(reloads > 0), 32'h0000_0001);
      chk(dma_ctl_pkg::a_req, 32'h0000_0008);
      g = grants.size();
      wait_grants(g + 1);
      chk(dma_ctl_pkg::a_idle, 32'h0000_0000);
      wr(dma_ctl_pkg::a_req, 32'h0000_0000);
      g = grants.size();
      wait_idle();
      repeat (30) @(posedge ref_clk);
      chk(dma_ctl_pkg::a_req, 32'h0000_0000);
      cmp(32'(grants.size() - g), 32'h0000_0000);
      cmp(32'(acks), 32'(grants.size()));
      cmp({29'h0, grants[g - 1]}, 32'h0000_0007);
      tally_and_finish();
   end
endmodule : dma_channel_control_regs_bench
